/* hw/trig_ctx_params.svh */
// Constants for the trigger context qualifier: address, field positions, reset value.
// Assumes inclusion by bare name from every file that decodes or packs the register.
`ifndef TRIG_CTX_PARAMS_SVH
`define TRIG_CTX_PARAMS_SVH

// Register number of the third trigger data slot.
`define CTXQ_ADDR 12'h7A3
// Trigger types that carry the qualifier in the third data slot.
`define CTXQ_TYPE_LO 4'h2
`define CTXQ_TYPE_HI 4'h6
// Reset value of every field.
`define CTXQ_RESET 64'h0
// Field positions in the 32-bit view.
`define V32_MHVAL_HI 31
`define V32_MHVAL_LO 26
`define V32_MHSEL_HI 25
`define V32_MHSEL_LO 23
`define V32_MASK_HI 19
`define V32_MASK_LO 18
`define V32_SVAL_HI 17
`define V32_SVAL_LO 2
`define V32_SSEL_HI 1
`define V32_SSEL_LO 0
// Field positions in the 64-bit view.
`define V64_MHVAL_HI 63
`define V64_MHVAL_LO 51
`define V64_MHSEL_HI 50
`define V64_MHSEL_LO 48
`define V64_MASK_HI 39
`define V64_MASK_LO 36
`define V64_SVAL_HI 33
`define V64_SVAL_LO 2
`define V64_SSEL_HI 1
`define V64_SSEL_LO 0
// Largest widths of the stored fields and of the hart's identifiers.
`define MHVAL_W 13
`define SVAL_W 32
`define MHCTX_W 14
`define VMID_MAX_W 14
`define ASID_MAX_W 16

`endif

/* hw/trig_ctx_pkg.sv */
// Types shared by the trigger context qualifier modules.
// Assumes trig_ctx_params.svh is on the include path.
`include "trig_ctx_params.svh"
package trig_ctx_pkg;
    // One trigger's stored qualification fields, always in 64-bit layout widths.
    typedef struct packed {
        logic [`MHVAL_W-1:0] mh_value;
        logic [2:0] mh_select;
        logic [3:0] byte_mask;
        logic [`SVAL_W-1:0] s_value;
        logic [1:0] s_select;
    } ctx_entry_t;

    // Machine/hypervisor select encodings.
    typedef enum logic [2:0] {
        MH_IGNORE = 3'h0,
        MH_CTX_LOW = 3'h1,
        MH_VMID_LOW = 3'h2,
        MH_RSVD_LOW = 3'h3,
        MH_CTX_FULL = 3'h4,
        MH_CTX_HIGH = 3'h5,
        MH_VMID_HIGH = 3'h6,
        MH_RSVD_HIGH = 3'h7
    } mh_select_t;

    // Supervisor select encodings.
    typedef enum logic [1:0] {
        S_IGNORE = 2'h0,
        S_CONTEXT = 2'h1,
        S_SPACE_ID = 2'h2,
        S_RSVD = 2'h3
    } s_select_t;
endpackage : trig_ctx_pkg

/* hw/ctx_if.sv */
// Hart context bundle carried from the top module to the per-trigger comparators.
// Assumes one driver (the top) and any number of readers on the same clock.
`timescale 1ns/1ns
`include "trig_ctx_params.svh"
interface ctx_if;
    logic [`MHCTX_W-1:0] mh_context;
    logic [`SVAL_W-1:0] s_context;
    logic [`VMID_MAX_W-1:0] vm_id;
    logic [`ASID_MAX_W-1:0] space_id;

    modport src (output mh_context, output s_context, output vm_id, output space_id);
    modport sink (input mh_context, input s_context, input vm_id, input space_id);
endinterface : ctx_if

/* hw/ctx_legalize.sv */
// Turns a register write in either view into legal stored fields.
// Assumes the caller only uses the result on a decoded write.
`timescale 1ns/1ns
`include "trig_ctx_params.svh"
module ctx_legalize
    import trig_ctx_pkg::*;
#(
    parameter int MHVAL_BITS = 13,
    parameter int SVAL_BITS = 32,
    parameter bit HAS_H = 1'b1,
    parameter bit HAS_S = 1'b1
) (
    input wire logic [63:0] wdata,
    input wire logic wide_view,
    output ctx_entry_t entry
);
    localparam logic [`MHVAL_W-1:0] MH_KEEP = `MHVAL_W'((1 << MHVAL_BITS) - 1);
    localparam logic [`SVAL_W-1:0] S_KEEP = `SVAL_W'((64'h1 << SVAL_BITS) - 64'h1);

    ctx_entry_t raw;

    // Unpack the chosen view; the narrow view zeroes the upper field bits.
    always_comb begin
        raw = '0;
        if (wide_view) begin
            raw.mh_value = wdata[`V64_MHVAL_HI:`V64_MHVAL_LO];
            raw.mh_select = wdata[`V64_MHSEL_HI:`V64_MHSEL_LO];
            raw.byte_mask = wdata[`V64_MASK_HI:`V64_MASK_LO];
            raw.s_value = wdata[`V64_SVAL_HI:`V64_SVAL_LO];
            raw.s_select = wdata[`V64_SSEL_HI:`V64_SSEL_LO];
        end else begin
            raw.mh_value = {7'h00, wdata[`V32_MHVAL_HI:`V32_MHVAL_LO]};
            raw.mh_select = wdata[`V32_MHSEL_HI:`V32_MHSEL_LO];
            raw.byte_mask = {2'h0, wdata[`V32_MASK_HI:`V32_MASK_LO]};
            raw.s_value = {16'h0000, wdata[`V32_SVAL_HI:`V32_SVAL_LO]};
            raw.s_select = wdata[`V32_SSEL_HI:`V32_SSEL_LO];
        end
    end

    // Keep only supported values; unsupported selects fall back to ignore, unsupported value bits clear to zero.
    always_comb begin
        entry = raw;
        entry.mh_value = raw.mh_value & MH_KEEP;
        entry.s_value = raw.s_value & S_KEEP;
        if (raw.mh_select == MH_RSVD_LOW || raw.mh_select == MH_RSVD_HIGH) begin
            entry.mh_select = MH_IGNORE;
        end else if (!HAS_H && raw.mh_select != MH_CTX_FULL) begin
            entry.mh_select = MH_IGNORE;
        end
        if (raw.s_select == S_RSVD) begin
            entry.s_select = S_IGNORE;
        end
        if (!HAS_S) begin
            entry.s_value = '0;
            entry.s_select = S_IGNORE;
        end
    end
endmodule : ctx_legalize

/* hw/ctx_match.sv */
// Evaluates one trigger's context qualification against the hart's context.
// Assumes the context bundle is stable on the same clock as the stored fields.
`timescale 1ns/1ns
`include "trig_ctx_params.svh"
module ctx_match
    import trig_ctx_pkg::*;
#(
    parameter int VMID_BITS = 14,
    parameter int ASID_BITS = 16
) (
    ctx_if.sink ctx,
    input ctx_entry_t entry,
    output logic ok
);
    localparam logic [`VMID_MAX_W-1:0] VM_KEEP = `VMID_MAX_W'((1 << VMID_BITS) - 1);
    localparam logic [`ASID_MAX_W-1:0] AS_KEEP = `ASID_MAX_W'((1 << ASID_BITS) - 1);

    logic mh_ok;
    logic s_ok;
    logic [`MHCTX_W-1:0] mh_cat;
    logic [3:0] byte_eq;

    assign mh_cat = {entry.mh_value, entry.mh_select[2]};

    // Per-byte supervisor context comparison, each byte excused by its mask bit.
    for (genvar b = 0; b < 4; b++) begin : g_byte
        assign byte_eq[b] = entry.byte_mask[b] ||
            (ctx.s_context[8*b+:8] == entry.s_value[8*b+:8]);
    end

    // Machine/hypervisor comparison, applied in every privilege mode.
    always_comb begin
        case (entry.mh_select)
            MH_CTX_FULL: mh_ok = ctx.mh_context[`MHVAL_W-1:0] == entry.mh_value;
            MH_CTX_LOW, MH_CTX_HIGH: mh_ok = ctx.mh_context == mh_cat;
            MH_VMID_LOW, MH_VMID_HIGH: mh_ok =
                (ctx.vm_id & VM_KEEP) == (mh_cat & VM_KEEP);
            default: mh_ok = 1'b1;
        endcase
    end

    // Supervisor comparison; the mask only matters for the context select.
    always_comb begin
        case (entry.s_select)
            S_CONTEXT: s_ok = &byte_eq;
            S_SPACE_ID: s_ok =
                (ctx.space_id & AS_KEEP) == (entry.s_value[`ASID_MAX_W-1:0] & AS_KEEP);
            default: s_ok = 1'b1;
        endcase
    end

    assign ok = mh_ok && s_ok;
endmodule : ctx_match

/* hw/trigger_context_filter.sv */
// Top of the trigger context qualifier: per-trigger storage, register port and match outputs.
// Assumes the register port and hart context come from logic on clk, and that the
// trigger index and selected trigger type are provided by the surrounding trigger unit.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`include "trig_ctx_params.svh"

// Notes on behaviour
// - 32-bit view in third slot, types 2..6
// - 64-bit view there when hart is wide
// - narrow write clears upper field bits
// - storage unchanged when hart width changes
// - optional bits may be tied to zero
// - select 0 ignores, 4 compares low context
// - selects 1,5 append select bit two
// - selects 2,6 compare VM ID low bits
// - 3,7 reserved; without hypervisor only 0,4
// - supervisor select 0 ignores, 1 compares
// - select 2 compares space ID by mode
// - mask bits 0,1 drop bytes 0,1
// - mask bits 2,3 drop bytes 2,3
// - mask applies only for context select
// - filters apply in every privilege mode
// - supervisor value and select zero without supervisor mode; byte mask kept
// - one copy per trigger, reset zero
// - trigger matches only when all conditions hold
module trigger_context_filter
    import trig_ctx_pkg::*;
#(
    parameter int NUM_TRIG = 4,
    parameter int MHVAL_BITS = 13,
    parameter int SVAL_BITS = 32,
    parameter int VMID_BITS = 14,
    parameter int ASID_BITS = 16,
    parameter bit HAS_H = 1'b1,
    parameter bit HAS_S = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] reg_addr,
    input wire logic [63:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [63:0] reg_rdata,
    input wire logic [$clog2(NUM_TRIG)-1:0] trig_index,
    input wire logic [3:0] trig_type,
    input wire logic hart_wide,
    input wire logic [`MHCTX_W-1:0] mh_context,
    input wire logic [`SVAL_W-1:0] s_context,
    input wire logic [`VMID_MAX_W-1:0] guest_vm_id,
    input wire logic [`ASID_MAX_W-1:0] sup_space_id,
    input wire logic [`ASID_MAX_W-1:0] virt_space_id,
    input wire logic virt_mode,
    output logic [NUM_TRIG-1:0] ctx_ok
);
    localparam int IDX_W = $clog2(NUM_TRIG);

    // Refuse settings that the field layout or the index port cannot serve.
    if (NUM_TRIG < 2 || NUM_TRIG > 64) begin : g_bad_num
        $error("NUM_TRIG must lie in 2..64");
    end
    if (MHVAL_BITS < 6 || MHVAL_BITS > `MHVAL_W) begin : g_bad_mh
        $error("MHVAL_BITS must lie in 6..13");
    end
    if (SVAL_BITS < 16 || SVAL_BITS > `SVAL_W) begin : g_bad_s
        $error("SVAL_BITS must lie in 16..32");
    end
    if (VMID_BITS < 1 || VMID_BITS > `VMID_MAX_W) begin : g_bad_vm
        $error("VMID_BITS must lie in 1..14");
    end
    if (ASID_BITS < 1 || ASID_BITS > `ASID_MAX_W) begin : g_bad_as
        $error("ASID_BITS must lie in 1..16");
    end

    // Whole register state of the block.
    typedef struct packed {
        ctx_entry_t [NUM_TRIG-1:0] entry;
        logic [63:0] rdata;
        logic [NUM_TRIG-1:0] ok;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    ctx_if ctx ();

    ctx_entry_t wr_entry;
    ctx_entry_t sel_entry;
    logic [NUM_TRIG-1:0] match_ok;
    logic slot_hit;
    logic index_valid;

    // True when the selected trigger type exposes the qualifier in its third slot.
    function automatic logic type_has_slot(input logic [3:0] t);
        type_has_slot = (t >= `CTXQ_TYPE_LO) && (t <= `CTXQ_TYPE_HI);
    endfunction : type_has_slot

    // Pack one stored entry into the view the hart currently uses.
    function automatic logic [63:0] pack_view(input ctx_entry_t e, input logic wide);
        logic [63:0] v;
        v = '0;
        if (wide) begin
            v[`V64_MHVAL_HI:`V64_MHVAL_LO] = e.mh_value;
            v[`V64_MHSEL_HI:`V64_MHSEL_LO] = e.mh_select;
            v[`V64_MASK_HI:`V64_MASK_LO] = e.byte_mask;
            v[`V64_SVAL_HI:`V64_SVAL_LO] = e.s_value;
            v[`V64_SSEL_HI:`V64_SSEL_LO] = e.s_select;
        end else begin
            v[`V32_MHVAL_HI:`V32_MHVAL_LO] = e.mh_value[5:0];
            v[`V32_MHSEL_HI:`V32_MHSEL_LO] = e.mh_select;
            v[`V32_MASK_HI:`V32_MASK_LO] = e.byte_mask[1:0];
            v[`V32_SVAL_HI:`V32_SVAL_LO] = e.s_value[15:0];
            v[`V32_SSEL_HI:`V32_SSEL_LO] = e.s_select;
        end
        pack_view = v;
    endfunction : pack_view

    // Hand the hart context to the comparators; the space ID follows the guest
    // translation while the hart runs in a virtual mode.
    assign ctx.mh_context = mh_context;
    assign ctx.s_context = s_context;
    assign ctx.vm_id = guest_vm_id;
    assign ctx.space_id = virt_mode ? virt_space_id : sup_space_id;

    // Decode of the register port; an index beyond the trigger count is unmapped.
    assign index_valid = 32'(trig_index) < NUM_TRIG;
    assign slot_hit = (reg_addr == `CTXQ_ADDR) && type_has_slot(trig_type) &&
        index_valid;
    assign sel_entry = index_valid ? state_r.entry[trig_index] : '0;

    // Turn the written word into legal fields for the view in use.
    ctx_legalize #(
        .MHVAL_BITS(MHVAL_BITS),
        .SVAL_BITS(SVAL_BITS),
        .HAS_H(HAS_H),
        .HAS_S(HAS_S)
    ) u_legalize (
        .wdata(reg_wdata),
        .wide_view(hart_wide),
        .entry(wr_entry)
    );

    // One comparator per trigger, each on its own stored fields.
    for (genvar i = 0; i < NUM_TRIG; i++) begin : g_match
        ctx_match #(
            .VMID_BITS(VMID_BITS),
            .ASID_BITS(ASID_BITS)
        ) u_match (
            .ctx(ctx.sink),
            .entry(state_r.entry[i]),
            .ok(match_ok[i])
        );
    end

    // Next-state: writes land in the selected trigger only, reads return the
    // selected trigger in the current view for exactly one cycle.
    always_comb begin
        state_nxt = state_r;
        state_nxt.rdata = '0;
        if (reg_wr && slot_hit) begin
            state_nxt.entry[trig_index] = wr_entry;
        end
        if (reg_rd && slot_hit) begin
            state_nxt.rdata = pack_view(sel_entry, hart_wide);
        end
        state_nxt.ok = match_ok;
    end

    // State register; every stored field starts at zero.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign reg_rdata = state_r.rdata;
    assign ctx_ok = state_r.ok;
endmodule : trigger_context_filter

/* tb/trigger_context_filter_props.sv */
// Checker for the trigger context qualifier: read answers, view layouts and match outputs.
// Assumes it is bound to trigger_context_filter and sees only that module's ports.
`timescale 1ns/1ns
`include "trig_ctx_params.svh"
module trigger_context_filter_chk #(
    parameter int NUM_TRIG = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] reg_addr,
    input wire logic [63:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [63:0] reg_rdata,
    input wire logic [$clog2(NUM_TRIG)-1:0] trig_index,
    input wire logic [3:0] trig_type,
    input wire logic hart_wide,
    input wire logic [NUM_TRIG-1:0] ctx_ok
);
    logic mapped;
    // A request reaches the register only at its address, for types two to six.
    assign mapped = reg_addr == `CTXQ_ADDR && trig_type >= 4'h2 && trig_type <= 4'h6
        && int'(trig_index) < NUM_TRIG;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 64'h0)
        else $error("read data not zero outside an answer");
    a_unmapped_zero: assert property ($past(reg_rd) && !$past(mapped) |-> reg_rdata == 64'h0)
        else $error("unmapped read returned data");
    a_narrow_gaps: assert property ($past(reg_rd) && !$past(hart_wide)
        |-> reg_rdata[63:32] == 32'h0 && reg_rdata[22:20] == 3'h0)
        else $error("narrow view has bits outside its fields");
    a_wide_gaps: assert property ($past(reg_rd) && $past(hart_wide)
        |-> reg_rdata[47:40] == 8'h0 && reg_rdata[35:34] == 2'h0)
        else $error("wide view has bits outside its fields");
    a_select_legal: assert property ($past(reg_rd) |-> reg_rdata[1:0] != 2'h3
        && ($past(hart_wide) ? reg_rdata[49:48] : reg_rdata[24:23]) != 2'h3)
        else $error("reserved select value kept");
    a_reset_ok: assert property ($rose(rst_n) |=> ctx_ok == {NUM_TRIG{1'b1}})
        else $error("qualification not passing after reset");
    a_mask_readback: assert property (reg_wr && mapped && hart_wide
        ##1 reg_rd && mapped && hart_wide && $stable(trig_index)
        |=> reg_rdata[39:36] == $past(reg_wdata[39:36], 2))
        else $error("byte mask not read back");
    a_narrow_clears: assert property (reg_wr && mapped && !hart_wide
        ##1 reg_rd && mapped && hart_wide && $stable(trig_index)
        |=> reg_rdata[63:57] == 7'h0 && reg_rdata[39:38] == 2'h0 && reg_rdata[33:18] == 16'h0)
        else $error("narrow write left upper field bits");
    c_wide_write: cover property (reg_wr && mapped && hart_wide);
    c_narrow_read: cover property (reg_rd && mapped && !hart_wide);
    c_no_match: cover property (ctx_ok != {NUM_TRIG{1'b1}});
endmodule : trigger_context_filter_chk

bind trigger_context_filter trigger_context_filter_chk #(.NUM_TRIG(NUM_TRIG)) i_chk (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_index(trig_index), .trig_type(trig_type),
    .hart_wide(hart_wide), .ctx_ok(ctx_ok));

/* tb/hart_ctx_model.sv */
// Model of the hart's context and translation registers that feed the qualifier.
// Assumes the bench updates one register per cycle on the hart clock.
`timescale 1ns/1ns
`include "trig_ctx_params.svh"
module hart_ctx_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic upd,
    input wire logic [2:0] upd_sel,
    input wire logic [31:0] upd_val,
    output logic [`MHCTX_W-1:0] mh_context,
    output logic [`SVAL_W-1:0] s_context,
    output logic [`VMID_MAX_W-1:0] guest_vm_id,
    output logic [`ASID_MAX_W-1:0] sup_space_id,
    output logic [`ASID_MAX_W-1:0] virt_space_id,
    output logic virt_mode
);
    // Registers take a new value one cycle after an update, as a CSR write does.
    // The mode flag only picks the space ID source; no mode gates the values.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {mh_context, s_context, guest_vm_id, sup_space_id, virt_space_id, virt_mode} <= '0;
        end else if (upd) begin
            case (upd_sel)
                3'h0: mh_context <= upd_val[`MHCTX_W-1:0];
                3'h1: guest_vm_id <= upd_val[`VMID_MAX_W-1:0];
                3'h2: s_context <= upd_val;
                3'h3: sup_space_id <= upd_val[`ASID_MAX_W-1:0];
                3'h4: virt_space_id <= upd_val[`ASID_MAX_W-1:0];
                default: virt_mode <= upd_val[0];
            endcase
        end
    end
endmodule : hart_ctx_model

/* tb/trigger_context_filter_tb.sv */
// Self-checking bench for the trigger context qualifier: both views and the match outputs.
// Assumes the design files, the checker and the hart context model are compiled first.
`timescale 1ns/1ns
`include "trig_ctx_params.svh"
module trigger_context_filter_tb;
    logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, hart_wide = 1'b0;
    logic upd = 1'b0, virt_mode;
    logic [11:0] reg_addr = 12'h0;
    logic [63:0] reg_wdata = 64'h0, reg_rdata, ones = '1, fld;
    logic [1:0] trig_index = 2'h0;
    logic [3:0] trig_type = 4'h2, ctx_ok;
    logic [2:0] upd_sel = 3'h0;
    logic [31:0] upd_val = 32'h0, s_context;
    logic [13:0] mh_context, guest_vm_id;
    logic [15:0] sup_space_id, virt_space_id;
    int err_count = 0, checks = 0, cycles = 0;
    trigger_context_filter i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .trig_index(trig_index), .trig_type(trig_type), .hart_wide(hart_wide),
        .mh_context(mh_context), .s_context(s_context), .guest_vm_id(guest_vm_id),
        .sup_space_id(sup_space_id), .virt_space_id(virt_space_id), .virt_mode(virt_mode),
        .ctx_ok(ctx_ok));
    hart_ctx_model i_hart (.clk(clk), .rst_n(rst_n), .upd(upd), .upd_sel(upd_sel),
        .upd_val(upd_val), .mh_context(mh_context), .s_context(s_context),
        .guest_vm_id(guest_vm_id), .sup_space_id(sup_space_id),
        .virt_space_id(virt_space_id), .virt_mode(virt_mode));
    // Free-running clock and a cycle ceiling against hangs.
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            $display("Error at %0t: timeout", $time);
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        $display("Checks %0d, errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask : chk64
    // Lets a field or context change reach the registered match outputs, then compares.
    task automatic chk_match(input logic [3:0] exp);
        repeat (3) @(posedge clk);
        #1;
        checks++;
        if (ctx_ok !== exp) begin
            err_count++;
            $display("Error at %0t: match %h, expected %h", $time, ctx_ok, exp);
        end
    endtask : chk_match
    task automatic wr(input logic [11:0] a, input logic [63:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [63:0] exp);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk64(reg_rdata, exp);
    endtask : rd
    task automatic try(input logic [63:0] f, input logic [2:0] s, input logic [31:0] v,
        input logic [3:0] exp);
        wr(`CTXQ_ADDR, f);
        upd <= 1'b1;
        upd_sel <= s;
        upd_val <= v;
        @(posedge clk);
        upd <= 1'b0;
        chk_match(exp);
    endtask : try
    function automatic logic [63:0] wide(input logic [12:0] mv, input logic [2:0] ms,
        input logic [3:0] bm, input logic [31:0] sv, input logic [1:0] ss);
        return {mv, ms, 8'h0, bm, 2'h0, sv, ss};
    endfunction : wide
    // Reset, register views and refusals, then the match cases on trigger zero.
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk_match(4'hF);
        hart_wide <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            trig_index <= 2'(i);
            rd(`CTXQ_ADDR, 64'h0);
        end
        wr(12'h7A2, ones);
        rd(12'h7A2, 64'h0);
        for (int t = 0; t < 16; t += 7) begin
            trig_type <= 4'(t + 1);
            wr(`CTXQ_ADDR, ones);
            rd(`CTXQ_ADDR, 64'h0);
        end
        trig_index <= 2'h1;
        for (int t = 2; t < 7; t++) begin
            trig_type <= 4'(t);
            fld = wide(13'(t), 3'h4, 4'(t), 32'(t), 2'h1);
            wr(`CTXQ_ADDR, fld);
            rd(`CTXQ_ADDR, fld);
        end
        trig_index <= 2'h2;
        wr(`CTXQ_ADDR, ones);
        rd(`CTXQ_ADDR, 64'hFFF8_00F3_FFFF_FFFC);
        hart_wide <= 1'b0;
        rd(`CTXQ_ADDR, 64'hFC0F_FFFC);
        hart_wide <= 1'b1;
        rd(`CTXQ_ADDR, 64'hFFF8_00F3_FFFF_FFFC);
        trig_index <= 2'h1;
        hart_wide <= 1'b0;
        wr(`CTXQ_ADDR, ones);
        hart_wide <= 1'b1;
        rd(`CTXQ_ADDR, 64'h01F8_0030_0003_FFFC);
        trig_index <= 2'h0;
        try(wide(13'h0123, 3'h4, 4'h0, 32'h0, 2'h0), 3'h0, 32'h0123, 4'hF);
        try(wide(13'h0123, 3'h4, 4'h0, 32'h0, 2'h0), 3'h0, 32'h2123, 4'hF);
        try(wide(13'h0123, 3'h4, 4'h0, 32'h0, 2'h0), 3'h0, 32'h0124, 4'hE);
        try(wide(13'h0123, 3'h0, 4'h0, 32'h0, 2'h0), 3'h0, 32'h0124, 4'hF);
        try(wide(13'h0123, 3'h5, 4'h0, 32'h0, 2'h0), 3'h0, 32'h0247, 4'hF);
        try(wide(13'h0123, 3'h1, 4'h0, 32'h0, 2'h0), 3'h0, 32'h0247, 4'hE);
        try(wide(13'h0123, 3'h6, 4'h0, 32'h0, 2'h0), 3'h1, 32'h0247, 4'hF);
        try(wide(13'h0123, 3'h2, 4'h0, 32'h0, 2'h0), 3'h1, 32'h0247, 4'hE);
        try(wide(13'h0, 3'h0, 4'hA, 32'h11223344, 2'h1), 3'h2, 32'hAA22BB44, 4'hF);
        try(wide(13'h0, 3'h0, 4'hA, 32'h11223344, 2'h1), 3'h2, 32'h11233344, 4'hE);
        try(wide(13'h0, 3'h0, 4'h0, 32'h11223344, 2'h1), 3'h2, 32'h11223344, 4'hF);
        try(wide(13'h0, 3'h0, 4'hF, 32'hBEEF, 2'h2), 3'h3, 32'hBEEF, 4'hF);
        try(wide(13'h0, 3'h0, 4'hF, 32'hBEEF, 2'h2), 3'h3, 32'hBEE0, 4'hE);
        try(wide(13'h0, 3'h0, 4'hF, 32'hBEEF, 2'h2), 3'h5, 32'h1, 4'hE);
        try(wide(13'h0, 3'h0, 4'hF, 32'hBEEF, 2'h2), 3'h4, 32'hBEEF, 4'hF);
        try(wide(13'h0123, 3'h4, 4'h0, 32'hBEEF, 2'h2), 3'h0, 32'h0123, 4'hF);
        try(wide(13'h0123, 3'h4, 4'h0, 32'hBEEF, 2'h2), 3'h4, 32'h0, 4'hE);
        tally_and_finish();
    end
endmodule : trigger_context_filter_tb
